// ### mialu_pkg.sv
// Constants and carrier types for the interrupt controller and link UART.
// Assumes a 200 MHz system clock and an 8-bit processor I/O port.
package mialu_pkg;

  // Clock and link timing.
  localparam int CLK_HZ = 200_000_000;
  localparam int OSC_HZ = 4_000_000;
  localparam int LINK_DIV = 10;
  localparam int PRESCALE = 16;
  localparam int LINK_TICK_CYC = CLK_HZ / (OSC_HZ / LINK_DIV);
  localparam logic [8:0] LINK_TICK_LAST = 9'(LINK_TICK_CYC - 1);
  localparam logic [3:0] SAMPLE_LAST = 4'(PRESCALE - 1);
  localparam logic [3:0] HALF_BIT = 4'(PRESCALE / 2 - 1);
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'ha;

  // I/O addresses.
  localparam logic [7:0] IO_RD_RXDATA = 8'h10;
  localparam logic [7:0] IO_RD_FLAGS = 8'h20;
  localparam logic [7:0] IO_RD_SOURCE = 8'h60;
  localparam logic [7:0] IO_WR_TXDATA = 8'h80;
  localparam logic [7:0] IO_WR_MASK = 8'h90;
  localparam logic [7:0] IO_WR_NMI_CLR = 8'ha0;
  localparam logic [7:0] IO_WR_TICK_CLR = 8'hb0;

  // Mask register bit positions and reset value.
  localparam int MASK_CHAIN = 0;
  localparam int MASK_BUS = 1;
  localparam int MASK_TICK = 2;
  localparam int MASK_TX = 3;
  localparam int MASK_RX = 4;
  localparam logic [4:0] MASK_RESET = 5'h00;

  // Priority codes.
  localparam logic [2:0] CODE_RX = 3'h4;
  localparam logic [2:0] CODE_TX = 3'h3;
  localparam logic [2:0] CODE_TICK = 3'h2;
  localparam logic [2:0] CODE_BUS = 3'h1;
  localparam logic [2:0] CODE_NONE = 3'h0;

  // Transmit buffering.
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // Status flags, low nibble of the flags register.
  typedef struct packed {
    logic tx_shift_empty;
    logic parity_flag;
    logic framing_flag;
    logic overrun_flag;
  } mialu_flags_s;

  // Maskable sources after gating.
  typedef struct packed {
    logic rx;
    logic tx;
    logic tick;
    logic bus;
  } mialu_src_s;

endpackage : mialu_pkg

// ### mialu_top.sv
// Maskable interrupt controller with priority vectoring and the serial link UART.
// Assumes a processor I/O port on the same clock and pins synchronised here.
//
// Overview of operation
// [R01] Request interrupts by driving the maskable or non-maskable request low.
// [R02] On acknowledge, drive the vector low byte onto the data bus.
// [R03] Processor branches to a fixed handler on non-maskable requests.
// [R04] Pending masked-source request holds the chain enable inactive.
// [R05] Mask gates five sources; non-maskable request is never masked.
// [R06] Seven bus-device lines merge into one group, each readable.
// [R07] Unmasked sources pass gates and a synchronising latch to the encoder.
// [R08] Encoder gives a request line and a code naming highest pending.
// [R09] Chain enable true only when its mask set and nothing pending.
// [R10] UART interrupts set on byte done, clear on load or read.
// [R11] Tick and watchdog requests stay until their reset strobes.
// [R12] Mask write enables ones and disables zeros.
// [R13] Source register read shows live bus-device lines, no side effect.
// [R14] Full holding and empty shifter move byte, start send, raise holding empty.
// [R15] Received byte to holding register raises ready; read clears and drives it.
// [R16] New byte before previous read raises overrun.
// [R17] Bad parity raises parity flag, missing stop raises framing flag.
// [R18] Overrun, framing, parity and shifter-empty read as one status register.
// [R19] Link is full duplex, odd parity, eight data, one stop, 25 kilobaud.
// [R20] Bit clocks come from the baud clock, prescaled by sixteen.
// [R21] Priority: receive 100, transmit 011, tick 010, bus group 001.
// [R22] Vector is the code shifted left one, other lines low.
// [R23] Reset clears all mask bits.
// [R24] Vector driven only on acknowledge with a pending request.
`timescale 1ns/1ps

// Transmit byte queue with valid and ready on both sides.
module mialu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Flags come from the count so full and empty are exact.
  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only, never reset, to keep it plain flip-flops.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= count + ONE;
      end else if (pop && !push) begin
        count <= count - ONE;
      end
    end
  end
endmodule : mialu_fifo

module mialu_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Processor I/O port.
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic int_ack,
  output logic [7:0] data_out,
  output logic data_oe,
  // Processor requests and chain control.
  output logic irq_n,
  output logic nmi_n,
  output logic chain_enable_in,
  // Pins from the board.
  input wire logic [6:0] bus_dev_irq_n,
  input wire logic tick_in,
  input wire logic watchdog_in,
  // Serial link.
  input wire logic rxd,
  output logic txd,
  output logic tx_fifo_ready
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} mialu_rx_e;

  logic [1:0] rst_pipe;
  logic rst_sync_n;
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  logic [6:0] bus_n;
  logic tick_s;
  logic tick_d;
  logic wdog_s;
  logic wdog_d;
  logic rxd_s;
  logic [4:0] mask;
  logic tick_interrupt;
  logic nmi_latch;
  mialu_pkg::mialu_src_s src_latch;
  mialu_pkg::mialu_src_s next_src;
  logic [2:0] code;
  logic any_pending;
  logic [8:0] link_cnt;
  logic link_baud_clock;
  logic wr_tx;
  logic rd_rx;
  logic rd_flags;
  logic rx_ready_clear_n;
  logic rx_output_enable;
  logic flag_select_n;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic fifo_in_ready;
  logic [7:0] tx_holding_reg;
  logic tx_holding_empty;
  logic [10:0] tx_shift_reg;
  logic [3:0] tx_bit;
  logic [3:0] tx_pre;
  logic load_shift;
  mialu_pkg::mialu_flags_s flags;
  mialu_rx_e rx_state;
  logic [3:0] rx_pre;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift_reg;
  logic rx_par;
  logic [7:0] rx_holding_reg;
  logic rx_data_ready;
  logic rx_done;

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // Two-stage synchronisers for every pin; only the second stage is read.
  // Reset values are the idle levels, so the edge detectors see no false edge.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 10'h3f9;
      pin_sync <= 10'h3f9;
    end else begin
      pin_meta <= {bus_dev_irq_n, tick_in, watchdog_in, rxd};
      pin_sync <= pin_meta;
    end
  end
  assign bus_n = pin_sync[9:3];
  assign tick_s = pin_sync[2];
  assign wdog_s = pin_sync[1];
  assign rxd_s = pin_sync[0];

  // Address decode of the I/O strobes.
  assign wr_tx = io_wr && (io_addr == mialu_pkg::IO_WR_TXDATA);
  assign rd_rx = io_rd && (io_addr == mialu_pkg::IO_RD_RXDATA);
  assign rd_flags = io_rd && (io_addr == mialu_pkg::IO_RD_FLAGS);
  assign rx_ready_clear_n = !rd_rx; // see [R15]
  assign rx_output_enable = !rd_rx;
  assign flag_select_n = !rd_flags;

  // Mask register: each data bit enables or disables its source.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask <= mialu_pkg::MASK_RESET; // see [R23]
    end else if (io_wr && io_addr == mialu_pkg::IO_WR_MASK) begin
      mask <= io_wdata[4:0]; // see [R12]
    end
  end

  // Tick and watchdog latches: a new edge wins over a reset strobe.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_d <= 1'b0;
      wdog_d <= 1'b0;
      tick_interrupt <= 1'b0;
      nmi_latch <= 1'b0;
    end else begin
      tick_d <= tick_s;
      wdog_d <= wdog_s;
      if (tick_s && !tick_d) begin
        tick_interrupt <= 1'b1;
      end else if (io_wr && io_addr == mialu_pkg::IO_WR_TICK_CLR) begin
        tick_interrupt <= 1'b0; // see [R11]
      end
      if (wdog_s && !wdog_d) begin
        nmi_latch <= 1'b1;
      end else if (io_wr && io_addr == mialu_pkg::IO_WR_NMI_CLR) begin
        nmi_latch <= 1'b0; // see [R11]
      end
    end
  end

  // Enabling gates ahead of the synchronising latch.
  always_comb begin
    next_src.rx = rx_data_ready && mask[mialu_pkg::MASK_RX]; // see [R05]
    next_src.tx = tx_holding_empty && !fifo_out_valid && mask[mialu_pkg::MASK_TX];
    next_src.tick = tick_interrupt && mask[mialu_pkg::MASK_TICK];
    next_src.bus = !(&bus_n) && mask[mialu_pkg::MASK_BUS]; // see [R06]
  end

  // Synchronising latch in front of the encoder.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      src_latch <= '0;
    end else begin
      src_latch <= next_src; // see [R07]
    end
  end

  // Priority encoder, receive highest.
  always_comb begin
    if (src_latch.rx) begin
      code = mialu_pkg::CODE_RX; // see [R21]
    end else if (src_latch.tx) begin
      code = mialu_pkg::CODE_TX;
    end else if (src_latch.tick) begin
      code = mialu_pkg::CODE_TICK;
    end else if (src_latch.bus) begin
      code = mialu_pkg::CODE_BUS;
    end else begin
      code = mialu_pkg::CODE_NONE;
    end
  end
  assign any_pending = |src_latch; // see [R08]

  // Request outputs and the chain enable; the chain is also held off while
  // a gated source is about to enter the latch, so both never request at once.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_n <= 1'b1;
      nmi_n <= 1'b1;
      chain_enable_in <= 1'b0;
    end else begin
      irq_n <= !any_pending; // see [R01]
      nmi_n <= !nmi_latch; // see [R05]
      chain_enable_in <= mask[mialu_pkg::MASK_CHAIN] && !any_pending
                         && !(|next_src); // see [R04] see [R09]
    end
  end

  // Read data and acknowledge vector, one cycle after the strobe.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else if (int_ack) begin
      data_out <= {4'h0, code, 1'b0}; // see [R22]
      data_oe <= any_pending; // see [R02] see [R24]
    end else if (io_rd) begin
      data_oe <= 1'b1;
      if (!rx_output_enable) begin
        data_out <= rx_holding_reg; // see [R15]
      end else if (!flag_select_n) begin
        data_out <= {4'h0, flags}; // see [R18]
      end else if (io_addr == mialu_pkg::IO_RD_SOURCE) begin
        data_out <= {1'b0, ~bus_n}; // see [R13]
      end else begin
        data_out <= 8'h00;
      end
    end else begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end
  end

  // Baud strobe: the oscillator divided by ten, counted in system clocks.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_cnt <= 9'h000;
      link_baud_clock <= 1'b0;
    end else if (link_cnt == mialu_pkg::LINK_TICK_LAST) begin
      link_cnt <= 9'h000;
      link_baud_clock <= 1'b1; // see [R20]
    end else begin
      link_cnt <= link_cnt + 9'h001;
      link_baud_clock <= 1'b0;
    end
  end

  // Processor writes queue here; a full queue drops the write, so software
  // polls tx_fifo_ready first.
  mialu_fifo #(
    .WIDTH(mialu_pkg::FIFO_WIDTH),
    .DEPTH(mialu_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_sync_n),
    .in_valid(wr_tx),
    .in_ready(fifo_in_ready),
    .in_data(io_wdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  assign fifo_out_ready = tx_holding_empty;
  assign load_shift = !tx_holding_empty && flags.tx_shift_empty;

  // Queue space mirrored to a pin.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_fifo_ready <= 1'b0;
    end else begin
      tx_fifo_ready <= fifo_in_ready;
    end
  end

  // Holding register: filled from the queue, emptied into the shifter.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_holding_reg <= 8'h00;
      tx_holding_empty <= 1'b1;
    end else if (fifo_out_valid && tx_holding_empty) begin
      tx_holding_reg <= fifo_out_data;
      tx_holding_empty <= 1'b0; // see [R10]
    end else if (load_shift) begin
      tx_holding_empty <= 1'b1; // see [R14]
    end
  end

  // Transmitter: start, eight data LSB first, odd parity, stop.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_shift_reg <= 11'h7ff;
      tx_bit <= 4'h0;
      tx_pre <= 4'h0;
      flags.tx_shift_empty <= 1'b1;
      txd <= 1'b1;
    end else if (load_shift) begin
      tx_shift_reg <= {1'b1, ~(^tx_holding_reg), tx_holding_reg, 1'b0}; // see [R19]
      tx_bit <= 4'h0;
      tx_pre <= 4'h0;
      flags.tx_shift_empty <= 1'b0;
    end else if (!flags.tx_shift_empty && link_baud_clock) begin
      txd <= tx_shift_reg[0];
      if (tx_pre == mialu_pkg::SAMPLE_LAST) begin
        tx_pre <= 4'h0;
        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
        if (tx_bit == mialu_pkg::FRAME_LAST) begin
          flags.tx_shift_empty <= 1'b1;
        end else begin
          tx_bit <= tx_bit + 4'h1;
        end
      end else begin
        tx_pre <= tx_pre + 4'h1; // see [R20]
      end
    end
  end

  // Receiver: centre on the start bit, then sample every sixteenth tick.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_state <= RX_IDLE;
      rx_pre <= 4'h0;
      rx_bit <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_par <= 1'b0;
      rx_done <= 1'b0;
      flags.parity_flag <= 1'b0;
      flags.framing_flag <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (link_baud_clock) begin
        case (rx_state)
          RX_IDLE: begin
            rx_pre <= 4'h0;
            if (!rxd_s) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (rx_pre == mialu_pkg::HALF_BIT) begin
              rx_pre <= 4'h0;
              rx_bit <= 4'h0;
              rx_state <= rxd_s ? RX_IDLE : RX_BITS;
            end else begin
              rx_pre <= rx_pre + 4'h1;
            end
          end
          RX_BITS: begin
            if (rx_pre == mialu_pkg::SAMPLE_LAST) begin
              rx_pre <= 4'h0;
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit <= mialu_pkg::DATA_LAST) begin
                rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
              end else if (rx_bit == mialu_pkg::DATA_LAST + 4'h1) begin
                rx_par <= rxd_s;
              end else begin
                flags.parity_flag <= !(^{rx_shift_reg, rx_par}); // see [R17]
                flags.framing_flag <= !rxd_s; // see [R17]
                rx_done <= 1'b1;
                rx_state <= RX_IDLE;
              end
            end else begin
              rx_pre <= rx_pre + 4'h1;
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Receive holding register; a new byte wins over a same-cycle read clear.
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_holding_reg <= 8'h00;
      rx_data_ready <= 1'b0;
      flags.overrun_flag <= 1'b0;
    end else if (rx_done) begin
      rx_holding_reg <= rx_shift_reg;
      rx_data_ready <= 1'b1; // see [R15]
      flags.overrun_flag <= rx_data_ready && rx_ready_clear_n; // see [R16]
    end else if (!rx_ready_clear_n) begin
      rx_data_ready <= 1'b0; // see [R10]
    end
  end

endmodule : mialu_top

// ### mialu_top_properties.sv
// Port-level assertions for the interrupt controller and link UART.
// Assumes binding to mialu_top, one clock and the raw active-low reset.
`timescale 1ns/1ps
module mialu_top_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Processor port.
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic int_ack,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  // Requests and board pins.
  input wire logic irq_n,
  input wire logic nmi_n,
  input wire logic chain_enable_in,
  input wire logic [6:0] bus_dev_irq_n,
  input wire logic watchdog_in
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Reset leaves every maskable source masked, so irq_n may not fall before a nonzero mask write.
  logic mask_written;
  logic nmi_clr;
  logic rd_only;
  assign nmi_clr = io_wr && io_addr == mialu_pkg::IO_WR_NMI_CLR;
  assign rd_only = io_rd && !int_ack;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_written <= 1'b0;
    end else if (io_wr && io_addr == mialu_pkg::IO_WR_MASK && io_wdata[4:0] != 5'h00) begin
      mask_written <= 1'b1;
    end
  end

  // Answers on the data bus and the request pins, and their causes.
  chk_read_answers: assert property (rd_only |=> data_oe)
    else $error("read got no answer");
  chk_oe_cause: assert property (data_oe |-> $past(io_rd) || $past(int_ack))
    else $error("data driven without request");
  chk_vector_form: assert property (int_ack ##1 data_oe |-> data_out[7:4] == 4'h0
    && data_out[0] == 1'b0 && data_out[3:1] != 3'h0)
    else $error("vector byte malformed");
  chk_vector_pending: assert property (data_oe && $past(int_ack) |-> !irq_n)
    else $error("vector without pending request");
  chk_chain_inhibit: assert property (!irq_n |-> !chain_enable_in)
    else $error("chain enabled while request pending");
  chk_quiet_reset: assert property (!mask_written |-> irq_n)
    else $error("request while all masked");
  chk_nmi_unmasked: assert property ($rose(watchdog_in) |-> ##[1:8] !nmi_n)
    else $error("watchdog request missing");
  chk_nmi_holds: assert property ($rose(nmi_n) |-> $past(nmi_clr, 1)
    || $past(nmi_clr, 2) || $past(nmi_clr, 3))
    else $error("nmi released without clear");
  chk_source_live: assert property (rd_only && io_addr == mialu_pkg::IO_RD_SOURCE
    && bus_dev_irq_n == $past(bus_dev_irq_n, 1) && bus_dev_irq_n == $past(bus_dev_irq_n, 2)
    && bus_dev_irq_n == $past(bus_dev_irq_n, 3) |=> data_out == {1'b0, ~$past(bus_dev_irq_n)})
    else $error("source read wrong");
  chk_flags_upper: assert property (rd_only && io_addr == mialu_pkg::IO_RD_FLAGS
    |=> data_out[7:4] == 4'h0)
    else $error("flags upper bits set");

  // Main scenarios.
  cov_vector: cover property (int_ack ##1 data_oe);
  cov_nmi: cover property ($fell(nmi_n));
  cov_chain: cover property ($rose(chain_enable_in));
endmodule : mialu_top_properties

bind mialu_top mialu_top_properties chk (
  .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
  .io_wdata(io_wdata), .int_ack(int_ack), .data_out(data_out), .data_oe(data_oe),
  .irq_n(irq_n), .nmi_n(nmi_n), .chain_enable_in(chain_enable_in),
  .bus_dev_irq_n(bus_dev_irq_n), .watchdog_in(watchdog_in)
);

// ### mialu_link_peer.sv
// Behavioural peer on the serial link: sends frames on rxd, captures frames on txd.
// Assumes the system clock and the 8000-cycle bit time of the package.
`timescale 1ns/1ps
module mialu_link_peer (
  // Clock.
  input wire logic clk,
  // Serial link.
  output logic rxd,
  input wire logic txd
);
  localparam int BIT_CYC = mialu_pkg::LINK_TICK_CYC * mialu_pkg::PRESCALE;

  // The line idles high between frames.
  initial rxd = 1'b1;

  // Start, eight data bits lowest first, odd parity, stop; parity may be spoiled.
  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    logic [10:0] fr;
    fr = {1'b1, (~^b) ^ bad_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= fr[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send_byte

  // Samples each bit in its middle, so a wrong bit time shows as wrong bits.
  task automatic catch_byte(output logic [7:0] b, output logic par, output logic stp,
                            output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (txd !== 1'b0 && n < 3 * BIT_CYC) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clk);
    ok = (txd === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    par = txd;
    repeat (BIT_CYC) @(posedge clk);
    stp = txd;
  endtask : catch_byte
endmodule : mialu_link_peer

// ### tb.sv
// Self-checking bench for the interrupt controller and link UART.
// Assumes the link peer model; one frame each way keeps the run short.
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, io_rd, io_wr, int_ack, tick_in, watchdog_in, rxd, txd;
  logic data_oe, irq_n, nmi_n, chain_enable_in, tx_fifo_ready;
  logic [7:0] io_addr, io_wdata, data_out, rx_b;
  logic [6:0] bus_dev_irq_n;
  logic rx_p, rx_s, rx_ok;
  int mismatches, checked;

  mialu_top uut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .int_ack(int_ack), .data_out(data_out), .data_oe(data_oe),
    .irq_n(irq_n), .nmi_n(nmi_n), .chain_enable_in(chain_enable_in),
    .bus_dev_irq_n(bus_dev_irq_n), .tick_in(tick_in), .watchdog_in(watchdog_in),
    .rxd(rxd), .txd(txd), .tx_fifo_ready(tx_fifo_ready));
  mialu_link_peer peer (.clk(clk), .rxd(rxd), .txd(txd));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask : cmp1

  // One bus cycle: request after an edge, held one cycle, answer taken with its release.
  task automatic io_cycle(input logic ack, input logic wr, input logic [7:0] a,
                          input logic [7:0] wd, output logic [7:0] d, output logic oe);
    @(posedge clk);
    #1;
    int_ack = ack;
    io_rd = !ack && !wr;
    io_wr = wr;
    io_addr = a;
    io_wdata = wd;
    @(posedge clk);
    #1;
    d = data_out;
    oe = data_oe;
    int_ack = 1'b0;
    io_rd = 1'b0;
    io_wr = 1'b0;
  endtask : io_cycle

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    logic [7:0] d;
    logic oe;
    io_cycle(1'b0, 1'b1, a, wd, d, oe);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    io_cycle(1'b0, 1'b0, a, 8'h00, d, oe);
    cmp1("read answered", 1'b1, oe);
    cmp8("read data", exp, d);
  endtask : rd

  task automatic ack(input logic exp_oe, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    io_cycle(1'b1, 1'b0, 8'h00, 8'h00, d, oe);
    cmp1("vector driven", exp_oe, oe);
    cmp8("vector", exp, d);
  endtask : ack

  // Bounded wait on a request pin: 0 irq_n, 1 nmi_n, 2 chain_enable_in.
  task automatic wait_pin(input int which, input logic lvl);
    logic v;
    for (int n = 0; n < 40; n++) begin
      v = (which == 0) ? irq_n : (which == 1) ? nmi_n : chain_enable_in;
      if (v === lvl) begin
        checked++;
        return;
      end
      @(posedge clk);
      #1;
    end
    mismatches++;
    $display("wrong value pin %0d expected %b seen %b", which, lvl, v);
    end_of_test();
  endtask : wait_pin

  task automatic t_reset();
    cmp1("irq_n", 1'b1, irq_n);
    cmp1("nmi_n", 1'b1, nmi_n);
    cmp1("chain", 1'b0, chain_enable_in);
    cmp1("txd idle", 1'b1, txd);
    ack(1'b0, 8'h00);
    rd(8'h30, 8'h00);
  endtask : t_reset

  task automatic t_bus_group();
    bus_dev_irq_n = 7'h5a;
    repeat (4) @(posedge clk);
    rd(mialu_pkg::IO_RD_SOURCE, 8'h25);
    cmp1("masked irq_n", 1'b1, irq_n);
    wr(mialu_pkg::IO_WR_MASK, 8'h02);
    wait_pin(0, 1'b0);
    ack(1'b1, 8'h02);
    rd(mialu_pkg::IO_RD_SOURCE, 8'h25);
    bus_dev_irq_n = 7'h7f;
    wait_pin(0, 1'b1);
    wr(mialu_pkg::IO_WR_MASK, 8'h01);
    wait_pin(2, 1'b1);
    bus_dev_irq_n = 7'h7e;
    wr(mialu_pkg::IO_WR_MASK, 8'h03);
    wait_pin(2, 1'b0);
  endtask : t_bus_group

  task automatic t_tick();
    wr(mialu_pkg::IO_WR_MASK, 8'h06);
    tick_in = 1'b1;
    repeat (8) @(posedge clk);
    ack(1'b1, 8'h04);
    ack(1'b1, 8'h04);
    wr(mialu_pkg::IO_WR_TICK_CLR, 8'h00);
    repeat (4) @(posedge clk);
    ack(1'b1, 8'h02);
    tick_in = 1'b0;
    bus_dev_irq_n = 7'h7f;
    wr(mialu_pkg::IO_WR_MASK, 8'h00);
    wait_pin(0, 1'b1);
  endtask : t_tick

  // The bench answers the watchdog request with the clear write; its acknowledge cycle gets no vector.
  task automatic t_nmi();
    watchdog_in = 1'b1;
    wait_pin(1, 1'b0);
    repeat (20) @(posedge clk);
    cmp1("nmi held", 1'b0, nmi_n);
    ack(1'b0, 8'h00);
    wr(mialu_pkg::IO_WR_NMI_CLR, 8'h00);
    wait_pin(1, 1'b1);
    watchdog_in = 1'b0;
  endtask : t_nmi

  // Both directions in one frame time; the received frame carries bad parity.
  task automatic t_link();
    wr(mialu_pkg::IO_WR_MASK, 8'h08);
    wait_pin(0, 1'b0);
    ack(1'b1, 8'h06);
    fork
      peer.send_byte(8'hc3, 1'b1);
      peer.catch_byte(rx_b, rx_p, rx_s, rx_ok);
      begin
        wr(mialu_pkg::IO_WR_TXDATA, 8'h5a);
        repeat (20) @(posedge clk);
        rd(mialu_pkg::IO_RD_FLAGS, 8'h00);
        ack(1'b1, 8'h06);
      end
    join
    repeat (mialu_pkg::LINK_TICK_CYC * mialu_pkg::PRESCALE) @(posedge clk);
    wr(mialu_pkg::IO_WR_MASK, 8'h18);
    repeat (4) @(posedge clk);
    ack(1'b1, 8'h08);
    rd(mialu_pkg::IO_RD_RXDATA, 8'hc3);
    repeat (4) @(posedge clk);
    ack(1'b1, 8'h06);
    rd(mialu_pkg::IO_RD_FLAGS, 8'h0c);
    cmp1("tx start", 1'b1, rx_ok);
    cmp8("tx byte", 8'h5a, rx_b);
    cmp1("tx parity", ~^8'h5a, rx_p);
    cmp1("tx stop", 1'b1, rx_s);
  endtask : t_link

  // Queue, holding and shift stages hold ten bytes; draining needs frames we cannot afford.
  task automatic t_fill();
    cmp1("queue ready", 1'b1, tx_fifo_ready);
    for (int i = 0; i < 11; i++) wr(mialu_pkg::IO_WR_TXDATA, 8'(i));
    repeat (3) @(posedge clk);
    cmp1("queue full", 1'b0, tx_fifo_ready);
  endtask : t_fill

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    int_ack = 1'b0;
    tick_in = 1'b0;
    watchdog_in = 1'b0;
    bus_dev_irq_n = 7'h7f;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_bus_group();
    t_tick();
    t_nmi();
    t_link();
    t_fill();
    end_of_test();
  end
endmodule : tb
